// File: core/dcm_pkg.sv
// Functional notes
// - Counter end flag sets when counter empties
// - Writing enable one clears counter end flag
// - Write zero after reading one clears flag
// - Access size: 00 byte, 01 word, 10 long
// - Mode: 00 normal, 01 block, 10 repeat
// - Size error clears enable, sets escape flag
// - Normal/repeat: error if counter below unit
// - Block mode: error if counter below block
// - Escape request while flag and enable set
// - Escape request drops when either clears
// - End request while flag and enable set
// - End request drops when either clears
// - Bit 10 reads zero, writes ignored
// - Early stop reported through escape flag
`default_nettype none
package dcm_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_MODE  = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_BLOCK = 8'h08;
  localparam logic [7:0] ADDR_STS   = 8'h0C;
  localparam logic [7:0] ADDR_MASK  = 8'h10;
  // Mode register bit positions
  localparam int BIT_ENABLE = 31;
  localparam int BIT_ESC    = 17;
  localparam int BIT_END    = 16;
  localparam int BIT_SZ_LO  = 14;
  localparam int BIT_MD_LO  = 12;
  localparam int BIT_SZEIE  = 11;
  localparam int BIT_RSVD   = 10;
  localparam int BIT_ESCIE  = 9;
  localparam int BIT_ENDIE  = 8;
  // Status and mask bit positions
  localparam int EV_END  = 0;
  localparam int EV_ESC  = 1;
  localparam int EV_SZER = 2;
  localparam int EV_W    = 3;
  localparam int CNT_W   = 16;
  // Field encodings
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] MD_NORM = 2'h0;
  localparam logic [1:0] MD_BLK  = 2'h1;
  localparam logic [1:0] MD_RPT  = 2'h2;
  // Bytes moved per request for each access size
  localparam logic [15:0] UNIT_BYTE = 16'h0001;
  localparam logic [15:0] UNIT_WORD = 16'h0002;
  localparam logic [15:0] UNIT_LONG = 16'h0004;
  localparam logic [15:0] CNT_ZERO  = 16'h0000;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
  // Mode register fields as software sees them
  typedef struct packed {
    logic       enable;     // Channel transfer enable
    logic       esc_flag;   // Escape flag
    logic       end_flag;   // Counter end flag
    logic [1:0] size;       // Access size
    logic [1:0] mode;       // Transfer mode
    logic       szer_ie;    // Size error enable
    logic       esc_ie;     // Escape interrupt enable
    logic       end_ie;     // Transfer end interrupt enable
  } dcm_mode_t;
  localparam dcm_mode_t MODE_RST = '0;
endpackage
`default_nettype wire

// File: core/dcm_channel_ctrl.sv
`default_nettype none
module dcm_channel_ctrl (
  input  wire logic        mclk,          // System clock, 100 MHz
  input  wire logic        sys_rst,       // Synchronous reset, active high
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB access phase
  input  wire logic        pwrite,        // APB direction
  input  wire logic [7:0]  paddr,         // APB byte address
  input  wire logic [31:0] pwdata,        // APB write data
  output logic [31:0]      prdata,        // APB read data
  output logic             pready,        // APB ready
  output logic             pslverr,       // APB error, unmapped address
  input  wire logic        xfer_req,      // New transfer request pulse
  input  wire logic        escape_req,    // Early stop pulse from channel
  output logic             xfer_grant,    // One request served, pulse
  output logic [1:0]       access_size,   // Current access size field
  output logic [1:0]       transfer_mode, // Current transfer mode field
  output logic             channel_on,    // Channel transfer enable
  output logic             end_irq,       // Transfer end request
  output logic             esc_irq,       // Escape end request
  output logic             irq            // Masked status interrupt
);

  // Register state
  dcm_pkg::dcm_mode_t              md_q, md_d;      // Mode register
  logic [dcm_pkg::CNT_W-1:0]       cnt_q, cnt_d;    // Transfer counter
  logic [dcm_pkg::CNT_W-1:0]       blk_q;           // Block size in bytes
  logic [dcm_pkg::EV_W-1:0]        sts_q, sts_d;    // Sticky events
  logic [dcm_pkg::EV_W-1:0]        msk_q;           // Interrupt mask
  logic                            end_arm_q;       // End flag read as one
  logic                            esc_arm_q;       // Escape flag read as one
  logic [31:0]                     rdata_q;         // Captured read data
  logic                            grant_q;         // Grant pulse register

  // Bus decode
  wire setup    = psel & ~penable;
  wire access   = psel & penable;
  wire wr       = access & pwrite;
  wire rd_setup = setup & ~pwrite;
  wire hit_mode = (paddr == dcm_pkg::ADDR_MODE);
  wire hit_cnt  = (paddr == dcm_pkg::ADDR_COUNT);
  wire hit_blk  = (paddr == dcm_pkg::ADDR_BLOCK);
  wire hit_sts  = (paddr == dcm_pkg::ADDR_STS);
  wire hit_msk  = (paddr == dcm_pkg::ADDR_MASK);
  wire mapped   = hit_mode | hit_cnt | hit_blk | hit_sts | hit_msk;
  wire wr_mode  = wr & hit_mode;
  wire rd_mode  = access & ~pwrite & hit_mode;

  // Software write to enable clears both flags
  wire en_set   = wr_mode & pwdata[dcm_pkg::BIT_ENABLE];
  // Zero written after a read of one clears a flag; a one has no effect
  wire end_clr  = en_set | (wr_mode & ~pwdata[dcm_pkg::BIT_END] & end_arm_q);
  wire esc_clr  = en_set | (wr_mode & ~pwdata[dcm_pkg::BIT_ESC] & esc_arm_q);

  // Bytes needed by one request
  logic [dcm_pkg::CNT_W-1:0] unit;
  always_comb begin
    unique case (md_q.size)
      dcm_pkg::SZ_BYTE: unit = dcm_pkg::UNIT_BYTE;
      dcm_pkg::SZ_WORD: unit = dcm_pkg::UNIT_WORD;
      dcm_pkg::SZ_LONG: unit = dcm_pkg::UNIT_LONG;
      default:          unit = dcm_pkg::UNIT_BYTE; // Prohibited code, acts as byte
    endcase
  end

  // Block mode needs a whole block, the others one access unit
  wire                        is_blk  = (md_q.mode == dcm_pkg::MD_BLK);
  wire [dcm_pkg::CNT_W-1:0]   need    = is_blk ? blk_q : unit;
  wire                        short   = (cnt_q < need);
  wire                        req_on  = xfer_req & md_q.enable;
  wire                        sz_err  = req_on & short & md_q.szer_ie;
  // With the check disabled a short count is drained to zero
  wire                        serve   = req_on & ~sz_err;
  wire [dcm_pkg::CNT_W-1:0]   cnt_nx  = short ? dcm_pkg::CNT_ZERO : cnt_q - need;
  wire                        done    = serve & (cnt_nx == dcm_pkg::CNT_ZERO);
  wire                        esc_ev  = sz_err | (escape_req & md_q.enable & ~done);

  // Mode register next state; hardware sets win over software clears
  always_comb begin
    md_d = md_q;
    if (wr_mode) begin
      md_d.enable  = pwdata[dcm_pkg::BIT_ENABLE];
      md_d.size    = pwdata[dcm_pkg::BIT_SZ_LO +: 2];
      md_d.mode    = pwdata[dcm_pkg::BIT_MD_LO +: 2];
      md_d.szer_ie = pwdata[dcm_pkg::BIT_SZEIE];
      md_d.esc_ie  = pwdata[dcm_pkg::BIT_ESCIE];
      md_d.end_ie  = pwdata[dcm_pkg::BIT_ENDIE];
    end
    if (end_clr) begin
      md_d.end_flag = 1'b0;
    end
    if (esc_clr) begin
      md_d.esc_flag = 1'b0;
    end
    // Counter emptied: flag up, channel stops
    if (done) begin
      md_d.end_flag = 1'b1;
      md_d.enable   = 1'b0;
    end
    // Size error or early stop: escape flag up, channel stops
    if (esc_ev) begin
      md_d.esc_flag = 1'b1;
      md_d.enable   = 1'b0;
    end
  end

  // Counter next state; a hardware decrement beats a software write
  always_comb begin
    cnt_d = cnt_q;
    if (wr & hit_cnt) begin
      cnt_d = pwdata[dcm_pkg::CNT_W-1:0];
    end
    if (serve) begin
      cnt_d = cnt_nx;
    end
  end

  // Event status: write one to clear, new events win
  wire [dcm_pkg::EV_W-1:0] ev_now = {sz_err, esc_ev, done};
  always_comb begin
    sts_d = sts_q;
    if (wr & hit_sts) begin
      sts_d = sts_q & ~pwdata[dcm_pkg::EV_W-1:0];
    end
    sts_d = sts_d | ev_now;
  end

  // Read data, reserved bit 10 and unused bits read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = dcm_pkg::DATA_ZERO;
    if (hit_mode) begin
      rd_mux[dcm_pkg::BIT_ENABLE]     = md_q.enable;
      rd_mux[dcm_pkg::BIT_ESC]        = md_q.esc_flag;
      rd_mux[dcm_pkg::BIT_END]        = md_q.end_flag;
      rd_mux[dcm_pkg::BIT_SZ_LO +: 2] = md_q.size;
      rd_mux[dcm_pkg::BIT_MD_LO +: 2] = md_q.mode;
      rd_mux[dcm_pkg::BIT_SZEIE]      = md_q.szer_ie;
      rd_mux[dcm_pkg::BIT_ESCIE]      = md_q.esc_ie;
      rd_mux[dcm_pkg::BIT_ENDIE]      = md_q.end_ie;
      rd_mux[dcm_pkg::BIT_RSVD]       = 1'b0;
    end else if (hit_cnt) begin
      rd_mux[dcm_pkg::CNT_W-1:0] = cnt_q;
    end else if (hit_blk) begin
      rd_mux[dcm_pkg::CNT_W-1:0] = blk_q;
    end else if (hit_sts) begin
      rd_mux[dcm_pkg::EV_W-1:0] = sts_q;
    end else if (hit_msk) begin
      rd_mux[dcm_pkg::EV_W-1:0] = msk_q;
    end
  end

  // Mode and counter registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      md_q  <= dcm_pkg::MODE_RST;
      cnt_q <= dcm_pkg::CNT_ZERO;
    end else begin
      md_q  <= md_d;
      cnt_q <= cnt_d;
    end
  end

  // Block size, status and mask registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      blk_q <= dcm_pkg::CNT_ZERO;
      sts_q <= '0;
      msk_q <= '0;
    end else begin
      sts_q <= sts_d;
      if (wr & hit_blk) begin
        blk_q <= pwdata[dcm_pkg::CNT_W-1:0];
      end
      if (wr & hit_msk) begin
        msk_q <= pwdata[dcm_pkg::EV_W-1:0];
      end
    end
  end

  // Read-before-clear tracking; a set or a write disarms, a read of one arms
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      end_arm_q <= 1'b0;
      esc_arm_q <= 1'b0;
    end else begin
      if (wr_mode | done) begin
        end_arm_q <= 1'b0;
      end else if (rd_mode & md_q.end_flag) begin
        end_arm_q <= 1'b1;
      end
      if (wr_mode | esc_ev) begin
        esc_arm_q <= 1'b0;
      end else if (rd_mode & md_q.esc_flag) begin
        esc_arm_q <= 1'b1;
      end
    end
  end

  // Read data captured in setup so it stands through the access cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q <= dcm_pkg::DATA_ZERO;
      grant_q <= 1'b0;
    end else begin
      grant_q <= serve;
      if (rd_setup) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Outputs; the slave never inserts wait states
  assign prdata        = rdata_q;
  assign pready        = 1'b1;
  assign pslverr       = access & ~mapped;
  assign xfer_grant    = grant_q;
  assign access_size   = md_q.size;
  assign transfer_mode = md_q.mode;
  assign channel_on    = md_q.enable;
  assign end_irq       = md_q.end_flag & md_q.end_ie;
  assign esc_irq       = md_q.esc_flag & md_q.esc_ie;
  assign irq           = |(sts_q & msk_q);

  // Request met with a count too small for it; a same-cycle count write is left out
  sequence s_short_req;
    md_q.enable && xfer_req && md_q.szer_ie && (cnt_q < need) && !(wr && hit_cnt);
  endsequence

  // Mode read that sees the end flag up, with no counter end in that cycle
  sequence s_read_one;
    rd_mode && md_q.end_flag && !done;
  endsequence

  // Mode write with the end flag bit at zero, with no counter end in that cycle
  sequence s_zero_write;
    wr_mode && !pwdata[dcm_pkg::BIT_END] && !done;
  endsequence

  // Counter end while the end interrupt stays enabled
  sequence s_end_set;
    done && md_q.end_ie && !(wr_mode && !pwdata[dcm_pkg::BIT_ENDIE]);
  endsequence

  chk_end_flag_set: assert property (@(posedge mclk) disable iff (sys_rst)
    done |=> md_q.end_flag && !md_q.enable)
    else $error("end flag not set on empty counter");

  chk_enable_clears: assert property (@(posedge mclk) disable iff (sys_rst)
    (en_set && !done) |=> !md_q.end_flag)
    else $error("enable write did not clear end flag");

  // An idle and a setup cycle sit between the read access and the write access
  chk_read_then_clr: assert property (@(posedge mclk) disable iff (sys_rst)
    s_read_one ##1 (!wr_mode && !done) [*2] ##1 s_zero_write |=> !md_q.end_flag)
    else $error("read then zero write did not clear end flag");

  chk_one_no_set: assert property (@(posedge mclk) disable iff (sys_rst)
    (!md_q.end_flag && !done) |=> !md_q.end_flag)
    else $error("end flag rose without counter end");

  chk_size_error: assert property (@(posedge mclk) disable iff (sys_rst)
    s_short_req |=> md_q.esc_flag && !md_q.enable && $stable(cnt_q))
    else $error("size error not reported");

  chk_block_need: assert property (@(posedge mclk) disable iff (sys_rst)
    (serve && is_blk && cnt_q >= blk_q) |=> cnt_q == $past(cnt_q) - $past(blk_q))
    else $error("block mode count step wrong");

  chk_unit_need: assert property (@(posedge mclk) disable iff (sys_rst)
    (serve && !is_blk && md_q.size == dcm_pkg::SZ_LONG && cnt_q >= dcm_pkg::UNIT_LONG)
    |=> cnt_q == $past(cnt_q) - dcm_pkg::UNIT_LONG)
    else $error("longword count step wrong");

  chk_esc_irq: assert property (@(posedge mclk) disable iff (sys_rst)
    (esc_ev && md_q.esc_ie && !wr_mode) |=> esc_irq)
    else $error("escape request not raised");

  chk_esc_drop: assert property (@(posedge mclk) disable iff (sys_rst)
    (esc_irq && wr_mode && !pwdata[dcm_pkg::BIT_ESCIE] && !esc_ev) |=> !esc_irq)
    else $error("escape request held after enable cleared");

  chk_end_irq: assert property (@(posedge mclk) disable iff (sys_rst)
    s_end_set |=> end_irq)
    else $error("end request not raised");

  chk_end_drop: assert property (@(posedge mclk) disable iff (sys_rst)
    (end_irq && wr_mode && !pwdata[dcm_pkg::BIT_ENDIE] && !done) |=> !end_irq)
    else $error("end request held after enable cleared");

  chk_rsvd_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    (rd_setup && hit_mode) |=> !prdata[dcm_pkg::BIT_RSVD])
    else $error("reserved bit read as one");

  chk_early_stop: assert property (@(posedge mclk) disable iff (sys_rst)
    (escape_req && md_q.enable && !done) |=> md_q.esc_flag && !md_q.enable)
    else $error("early stop not flagged");

  // Longword request against a count under four bytes is refused
  chk_long_short: assert property (@(posedge mclk) disable iff (sys_rst)
    (xfer_req && md_q.enable && md_q.szer_ie && !is_blk && md_q.size == dcm_pkg::SZ_LONG
    && cnt_q < dcm_pkg::UNIT_LONG) |=> !xfer_grant && md_q.esc_flag)
    else $error("short longword request was served");

  chk_block_short: assert property (@(posedge mclk) disable iff (sys_rst)
    (xfer_req && md_q.enable && md_q.szer_ie && is_blk && cnt_q < blk_q)
    |=> !xfer_grant && !md_q.enable)
    else $error("short block request was served");

  // Reset is watched on its own, so no disable here
  chk_reset_zero: assert property (@(posedge mclk)
    sys_rst |=> md_q == dcm_pkg::MODE_RST && cnt_q == dcm_pkg::CNT_ZERO)
    else $error("fields not zero after reset");

endmodule // dcm_channel_ctrl
`default_nettype wire

// File: testbench/dcm_req_source.sv
`default_nettype none
// Channel-side requester: issues transfer requests and counts grants
module dcm_req_source (
  input  wire logic mclk,       // System clock
  input  wire logic sys_rst,    // Synchronous reset
  input  wire logic xfer_grant, // Grant pulse from the channel
  output logic      xfer_req    // Request pulse to the channel
);
  timeunit 1ns;
  timeprecision 1ns;
  int grants; // Served requests since reset
  initial xfer_req = 1'b0;
  // A refused request never shows here, so the count proves refusals
  always @(posedge mclk) begin
    if (sys_rst) begin
      grants <= 0;
    end else if (xfer_grant === 1'b1) begin
      grants <= grants + 1;
    end
  end
  // Back-to-back pulses, one per cycle, the tightest spacing allowed
  task automatic send(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge mclk);
      xfer_req <= 1'b1;
    end
    @(posedge mclk);
    xfer_req <= 1'b0;
  endtask
endmodule // dcm_req_source
`default_nettype wire

// File: testbench/dcm_channel_ctrl_bench.sv
`default_nettype none
module dcm_channel_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, sys_rst, psel, penable, pwrite, escape_req, xfer_req, err;
  logic [7:0]  paddr;                // APB address
  logic [31:0] pwdata, prdata, rd;   // APB data and last read
  logic        pready, pslverr, xfer_grant, channel_on, end_irq, esc_irq, irq;
  logic [1:0]  access_size, transfer_mode;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc = 0;
  dcm_channel_ctrl dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .xfer_req(xfer_req), .escape_req(escape_req),
    .xfer_grant(xfer_grant), .access_size(access_size), .transfer_mode(transfer_mode),
    .channel_on(channel_on), .end_irq(end_irq), .esc_irq(esc_irq), .irq(irq));
  dcm_req_source src (.mclk(mclk), .sys_rst(sys_rst), .xfer_grant(xfer_grant),
    .xfer_req(xfer_req));
  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Hang guard: a few hundred cycles cover every test
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for pready, never assumes a latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Mode word: enable, size, mode, {size-err ie, esc ie, end ie}
  function automatic logic [31:0] mw(logic en, logic [1:0] sz, logic [1:0] md,
                                     logic [2:0] ie);
    mw = {en, 15'h0000, sz, md, ie[2], 1'b0, ie[1:0], 8'h00};
  endfunction
  // Let the edge's updates land before looking
  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic t_reset;
    apb(1'b0, dcm_pkg::ADDR_MODE, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({channel_on, end_irq, esc_irq, irq, access_size, transfer_mode}, 0);
    $display("reset test done");
  endtask
  // Every legal size and mode, with the reserved bit forced high
  task automatic t_fields;
    for (int s = 0; s < 3; s++) begin
      for (int m = 0; m < 3; m++) begin
        apb(1'b1, dcm_pkg::ADDR_MODE, mw(1'b0, 2'(s), 2'(m), 3'h0) | 32'h0000_0400);
        apb(1'b0, dcm_pkg::ADDR_MODE, 32'h0000_0000);
        chk(rd, mw(1'b0, 2'(s), 2'(m), 3'h0));
        chk({access_size, transfer_mode}, {2'(s), 2'(m)});
      end
    end
    apb(1'b1, 8'h20, 32'hFFFF_FFFF);
    chk(err, 1'b1);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({err, rd}, {1'b1, 32'h0000_0000});
    $display("field test done");
  endtask
  task automatic t_end;
    apb(1'b1, dcm_pkg::ADDR_COUNT, 32'h0000_0004);
    apb(1'b1, dcm_pkg::ADDR_MASK, 32'h0000_0001);
    apb(1'b1, dcm_pkg::ADDR_MODE, mw(1'b1, dcm_pkg::SZ_BYTE, dcm_pkg::MD_NORM, 3'h1));
    src.send(4);
    settle;
    chk(src.grants, 4);
    chk({channel_on, end_irq, irq}, 3'b011);
    apb(1'b0, dcm_pkg::ADDR_MODE, 32'h0000_0000);
    chk(rd, mw(1'b0, dcm_pkg::SZ_BYTE, dcm_pkg::MD_NORM, 3'h1) | 32'h0001_0000);
    // Writing the flag as one must leave it set
    apb(1'b1, dcm_pkg::ADDR_MODE, rd);
    settle;
    chk(end_irq, 1'b1);
    // Enable off drops the request; a zero write with no read before it keeps the flag
    apb(1'b1, dcm_pkg::ADDR_MODE, mw(1'b0, dcm_pkg::SZ_BYTE, dcm_pkg::MD_NORM, 3'h0));
    settle;
    chk(end_irq, 1'b0);
    apb(1'b0, dcm_pkg::ADDR_MODE, 32'h0000_0000);
    chk(rd, 32'h0001_0000);
    apb(1'b1, dcm_pkg::ADDR_MODE, mw(1'b0, dcm_pkg::SZ_BYTE, dcm_pkg::MD_NORM, 3'h1));
    settle;
    chk(end_irq, 1'b0);
    apb(1'b1, dcm_pkg::ADDR_STS, 32'h0000_0001);
    settle;
    chk(irq, 1'b0);
    $display("end test done");
  endtask
  task automatic t_size_err;
    apb(1'b1, dcm_pkg::ADDR_COUNT, 32'h0000_0003);
    apb(1'b1, dcm_pkg::ADDR_MODE, mw(1'b1, dcm_pkg::SZ_LONG, dcm_pkg::MD_RPT, 3'h6));
    src.send(1);
    settle;
    chk(src.grants, 4);
    chk({channel_on, esc_irq}, 2'b01);
    apb(1'b0, dcm_pkg::ADDR_STS, 32'h0000_0000);
    chk(rd, 32'h0000_0006);
    apb(1'b1, dcm_pkg::ADDR_MODE, mw(1'b1, dcm_pkg::SZ_LONG, dcm_pkg::MD_RPT, 3'h2));
    settle;
    chk({channel_on, esc_irq}, 2'b10);
    // Early stop with the counter still non-zero
    @(posedge mclk);
    escape_req <= 1'b1;
    @(posedge mclk);
    escape_req <= 1'b0;
    settle;
    chk({channel_on, esc_irq}, 2'b01);
    apb(1'b1, dcm_pkg::ADDR_MODE, mw(1'b0, dcm_pkg::SZ_LONG, dcm_pkg::MD_RPT, 3'h0));
    settle;
    chk(esc_irq, 1'b0);
    $display("size error test done");
  endtask
  // First request fits the block, the back-to-back second does not
  task automatic t_block;
    apb(1'b1, dcm_pkg::ADDR_STS, 32'h0000_0007);
    apb(1'b1, dcm_pkg::ADDR_BLOCK, 32'h0000_0008);
    apb(1'b1, dcm_pkg::ADDR_COUNT, 32'h0000_000C);
    apb(1'b1, dcm_pkg::ADDR_MODE, mw(1'b1, dcm_pkg::SZ_BYTE, dcm_pkg::MD_BLK, 3'h6));
    src.send(2);
    settle;
    chk(src.grants, 5);
    chk({channel_on, esc_irq}, 2'b01);
    apb(1'b0, dcm_pkg::ADDR_COUNT, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    $display("block test done");
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    escape_req = 1'b0;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_fields();
    t_end();
    t_size_err();
    t_block();
    test_done();
  end
endmodule // dcm_channel_ctrl_bench
`default_nettype wire
